// >>> shared/csb_cfg.svh
/*
  Constants of the chip status byte block: state codes, FIFO figures,
  header field positions and the command strobe address range.
  Assumes inclusion by every file of the block that needs a number.
*/
// Behaviour
// - One status byte goes out on the serial output for every header, data or strobe byte taken in.
// - Bit 7 stays high until the crystal runs and the core supply is stable, then drops low.
// - Bits 6:4 give the main state: 000 idle, 001 receive, 010 transmit, 011 synth on and TX ready.
// - Calibration reports 100 and PLL settling 101, though transitional states may report 000.
// - A receive FIFO overflow reports 110 until the host issues the receive flush strobe; a pending transmit underflow reports 111 over it.
// - A transmit FIFO underflow reports 111 until the host issues the transmit flush strobe.
// - On a read header, bits 3:0 give the bytes waiting in the receive FIFO.
// - On a write header, bits 3:0 give the free locations in the transmit FIFO.
// - The count saturates at 15: RX holding 15 or more, or TX holding 49 or fewer.
// - In idle only the crystal oscillator and digital core stay powered.
// - Every byte on the link moves most significant bit first.
// - A transaction opens with a header of read/write bit, burst bit and 6-bit address.
// - During TX FIFO writes the free count is taken before the byte in flight is stored.
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// Main state codes
`define CSB_CODE_IDLE 3'h0
`define CSB_CODE_RX 3'h1
`define CSB_CODE_TX 3'h2
`define CSB_CODE_SYNTH_ON 3'h3
`define CSB_CODE_CALIBRATE 3'h4
`define CSB_CODE_SETTLING 3'h5
`define CSB_CODE_RX_OVERRUN 3'h6
`define CSB_CODE_TX_STARVED 3'h7

// FIFO figures
`define CSB_FIFO_DEPTH 7'h40
`define CSB_COUNT_SAT 7'h0f
`define CSB_COUNT_MAX 4'hf

// Header layout and strobe address range
`define CSB_HDR_RW_BIT 7
`define CSB_HDR_BURST_BIT 6
`define CSB_STROBE_ADDR_LO 6'h30
`define CSB_STROBE_ADDR_HI 6'h3d

// Bit count values: reset and last bit
`define CSB_BIT_COUNT_RESET 3'h0
`define CSB_LAST_BIT 3'h7

`endif

// >>> shared/csb_pkg.sv
/*
  Types of the chip status byte block.
  Assumes the constant header is on the include path.
*/
package csb_pkg;

  // Kind of byte the link expects next
  typedef enum logic [1:0] {
    CSB_SLOT_HEADER,
    CSB_SLOT_ONE_DATA,
    CSB_SLOT_BURST
  } csb_slot_type;

endpackage

// >>> shared/csb_snap_if.sv
/*
  Snapshot carrier between the core-clock status logic and the
  serial-clock shifter. Assumes the core holds the fields stable
  for most of each byte slot and the link only toggles byte_tgl.
*/
`timescale 1ns/100ps
`default_nettype none
interface csb_snap_if;
  logic not_ready;
  logic [2:0] state_code;
  logic [3:0] rx_avail;
  logic [3:0] tx_free;
  logic byte_tgl;
  modport core (output not_ready, state_code, rx_avail, tx_free, input byte_tgl);
  modport link (input not_ready, state_code, rx_avail, tx_free, output byte_tgl);
endinterface
`default_nettype wire

// >>> design/csb_link_shift.sv
/*
  Serial-clock side: counts bits, decodes headers, shifts the status
  byte out on falling edges. Assumes SCLK idles low, the host samples
  on rising edges, and chip select high clears all link state.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csb_cfg.svh"
module csb_link_shift
  import csb_pkg::*;
(
  // Serial pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  // Snapshot from the core
  csb_snap_if.link snap
);

  logic [2:0] cnt_r, cnt_nxt;
  logic [6:0] in_r, in_nxt;
  logic rw_r, rw_nxt;
  logic tgl_r, tgl_nxt;
  csb_slot_type slot_r, slot_nxt;
  logic b7_r, b7_nxt;
  logic [6:0] so_r, so_nxt;
  logic [7:0] hdr;
  logic in_range;

  // Rising edge: bit count, header decode, byte slot toggle
  always_comb begin
    cnt_nxt = cnt_r + 3'h1;
    in_nxt = {in_r[5:0], si_in};
    hdr = {in_r, si_in};
    in_range = (hdr[5:0] >= `CSB_STROBE_ADDR_LO) && (hdr[5:0] <= `CSB_STROBE_ADDR_HI);
    rw_nxt = rw_r;
    tgl_nxt = tgl_r;
    slot_nxt = slot_r;
    if (cnt_r == `CSB_BIT_COUNT_RESET) begin
      tgl_nxt = ~tgl_r;
      if (slot_r == CSB_SLOT_HEADER) begin
        rw_nxt = si_in;
      end
    end
    if (cnt_r == `CSB_LAST_BIT) begin
      unique case (slot_r)
        CSB_SLOT_HEADER: begin
          if (in_range) begin
            slot_nxt = hdr[`CSB_HDR_RW_BIT] ? CSB_SLOT_ONE_DATA : CSB_SLOT_HEADER;
          end else begin
            slot_nxt = hdr[`CSB_HDR_BURST_BIT] ? CSB_SLOT_BURST : CSB_SLOT_ONE_DATA;
          end
        end
        CSB_SLOT_ONE_DATA: slot_nxt = CSB_SLOT_HEADER;
        CSB_SLOT_BURST: slot_nxt = CSB_SLOT_BURST;
      endcase
    end
  end

  // Chip select high ends the frame and clears the link state
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt_r <= `CSB_BIT_COUNT_RESET;
      in_r <= 7'h00;
      rw_r <= 1'b0;
      tgl_r <= 1'b0;
      slot_r <= CSB_SLOT_HEADER;
    end else begin
      cnt_r <= cnt_nxt;
      in_r <= in_nxt;
      rw_r <= rw_nxt;
      tgl_r <= tgl_nxt;
      slot_r <= slot_nxt;
    end
  end

  // Falling edge: bit 7 phase, then load and shift bits 6:0
  always_comb begin
    b7_nxt = b7_r;
    so_nxt = so_r;
    if (cnt_r == `CSB_BIT_COUNT_RESET) begin
      b7_nxt = 1'b1;
    end else if (cnt_r == 3'h1) begin
      b7_nxt = 1'b0;
      so_nxt = {snap.state_code, rw_r ? snap.rx_avail : snap.tx_free};
    end else begin
      so_nxt = {so_r[5:0], 1'b0};
    end
  end

  // Output register group on the falling edge
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      b7_r <= 1'b1;
      so_r <= 7'h00;
    end else begin
      b7_r <= b7_nxt;
      so_r <= so_nxt;
    end
  end

  // Serial output and byte slot event
  assign so_out = b7_r ? snap.not_ready : so_r[6];
  assign snap.byte_tgl = tgl_r;

  // Link checks
  a_msb_first_shift: assert property (@(negedge sclk_in) disable iff (cs_n_in)
    (cnt_r > 3'h2) |-> (so_r[6] == $past(so_r[5])))
    else $error("status bits not shifted msb first");
  a_header_rw_taken: assert property (@(posedge sclk_in) disable iff (cs_n_in)
    (slot_r == CSB_SLOT_HEADER && cnt_r == `CSB_BIT_COUNT_RESET) |=> (rw_r == $past(si_in)))
    else $error("header direction bit not captured");
  c_burst_seen: cover property (@(posedge sclk_in) disable iff (cs_n_in)
    slot_r == CSB_SLOT_BURST ##8 slot_r == CSB_SLOT_BURST);

endmodule
`default_nettype wire

// >>> design/csb_status_top.sv
/*
  Chip status byte block: builds readiness, state code and FIFO counts
  on the core clock, hands a snapshot per byte slot to the serial-clock
  shifter and drives the serial output. Assumes the radio state machine,
  FIFOs and strobe decode live elsewhere on the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csb_cfg.svh"
module csb_status_top
  import csb_pkg::*;
(
  // Core clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  // Serial link pins
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_SI_IN,
  output logic SPI_SO_OUT,
  output logic SPI_SO_OE_OUT,
  // Readiness sources
  input wire logic CRYSTAL_OSCILLATOR_RUN_IN,
  input wire logic SUPPLY_STABLE_IN,
  // Radio state and FIFO events
  input wire logic [2:0] MAIN_STATE_IN,
  input wire logic TRANSITIONAL_IN,
  input wire logic RX_OVERFLOW_IN,
  input wire logic TX_UNDERFLOW_IN,
  input wire logic RECEIVE_FLUSH_STROBE_IN,
  input wire logic TRANSMIT_FLUSH_STROBE_IN,
  // FIFO fill levels
  input wire logic [6:0] RX_FILL_IN,
  input wire logic [6:0] TX_FILL_IN,
  // Status outputs
  output logic CHIP_NOT_READY_FLAG_OUT,
  output logic [2:0] STATE_CODE_OUT,
  output logic MODULES_POWER_OUT,
  output logic [7:0] CHIP_STATUS_SNAPSHOT_OUT
);

  // Saturating 4-bit count of a 7-bit level
  function automatic logic [3:0] sat4(input logic [6:0] level);
    sat4 = (level >= `CSB_COUNT_SAT) ? `CSB_COUNT_MAX : level[3:0];
  endfunction

  csb_snap_if snap ();

  logic xo_s1_r, xo_s2_r, vdd_s1_r, vdd_s2_r;
  logic cs_s1_r, cs_s2_r;
  logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic nrdy_r, nrdy_nxt;
  logic ovf_r, ovf_nxt;
  logic udf_r, udf_nxt;
  logic [2:0] code_r, code_nxt;
  logic pwr_r, pwr_nxt;
  logic offer_upd;
  logic offer_nrdy_r, offer_nrdy_nxt;
  logic [2:0] offer_code_r, offer_code_nxt;
  logic [3:0] offer_rx_r, offer_rx_nxt;
  logic [3:0] offer_tx_r, offer_tx_nxt;
  logic [6:0] tx_free_lvl;

  // Synchronisers for pins and the serial-clock byte toggle
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      xo_s1_r <= 1'b0;
      xo_s2_r <= 1'b0;
      vdd_s1_r <= 1'b0;
      vdd_s2_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      xo_s1_r <= CRYSTAL_OSCILLATOR_RUN_IN;
      xo_s2_r <= xo_s1_r;
      vdd_s1_r <= SUPPLY_STABLE_IN;
      vdd_s2_r <= vdd_s1_r;
      cs_s1_r <= SPI_CS_N_IN;
      cs_s2_r <= cs_s1_r;
      tgl_s1_r <= snap.byte_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // Readiness, sticky FIFO faults, reported state and power
  always_comb begin
    nrdy_nxt = !(xo_s2_r && vdd_s2_r);
    ovf_nxt = RX_OVERFLOW_IN || (ovf_r && !RECEIVE_FLUSH_STROBE_IN);
    udf_nxt = TX_UNDERFLOW_IN || (udf_r && !TRANSMIT_FLUSH_STROBE_IN);
    if (udf_nxt) begin
      code_nxt = `CSB_CODE_TX_STARVED;
    end else if (ovf_nxt) begin
      code_nxt = `CSB_CODE_RX_OVERRUN;
    end else if (TRANSITIONAL_IN) begin
      code_nxt = `CSB_CODE_IDLE;
    end else begin
      code_nxt = MAIN_STATE_IN;
    end
    pwr_nxt = (code_nxt != `CSB_CODE_IDLE);
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      nrdy_r <= 1'b1;
      ovf_r <= 1'b0;
      udf_r <= 1'b0;
      code_r <= `CSB_CODE_IDLE;
      pwr_r <= 1'b0;
    end else begin
      nrdy_r <= nrdy_nxt;
      ovf_r <= ovf_nxt;
      udf_r <= udf_nxt;
      code_r <= code_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // Snapshot refresh: idle bus, or once after each byte slot opens
  // Readiness stays live so a selected host sees it drop while waiting
  assign offer_upd = cs_s2_r || (tgl_s2_r != tgl_s3_r);
  assign tx_free_lvl = `CSB_FIFO_DEPTH - TX_FILL_IN;

  always_comb begin
    offer_nrdy_nxt = nrdy_r;
    offer_code_nxt = offer_code_r;
    offer_rx_nxt = offer_rx_r;
    offer_tx_nxt = offer_tx_r;
    if (offer_upd) begin
      offer_code_nxt = code_r;
      offer_rx_nxt = sat4(RX_FILL_IN);
      offer_tx_nxt = sat4(tx_free_lvl);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      offer_nrdy_r <= 1'b1;
      offer_code_r <= `CSB_CODE_IDLE;
      offer_rx_r <= 4'h0;
      offer_tx_r <= 4'h0;
    end else begin
      offer_nrdy_r <= offer_nrdy_nxt;
      offer_code_r <= offer_code_nxt;
      offer_rx_r <= offer_rx_nxt;
      offer_tx_r <= offer_tx_nxt;
    end
  end

  // Snapshot onto the carrier
  assign snap.not_ready = offer_nrdy_r;
  assign snap.state_code = offer_code_r;
  assign snap.rx_avail = offer_rx_r;
  assign snap.tx_free = offer_tx_r;

  // Serial-clock shifter
  csb_link_shift u_link (
    .sclk_in(SPI_SCLK_IN),
    .cs_n_in(SPI_CS_N_IN),
    .si_in(SPI_SI_IN),
    .so_out(SPI_SO_OUT),
    .snap(snap)
  );

  // Output drive follows chip select directly
  assign SPI_SO_OE_OUT = !SPI_CS_N_IN;
  assign CHIP_NOT_READY_FLAG_OUT = nrdy_r;
  assign STATE_CODE_OUT = code_r;
  assign MODULES_POWER_OUT = pwr_r;
  assign CHIP_STATUS_SNAPSHOT_OUT = {offer_nrdy_r, offer_code_r, offer_rx_r};

  // Core-domain checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_ready_flag_drop: assert property (
    (CRYSTAL_OSCILLATOR_RUN_IN && SUPPLY_STABLE_IN) [*3] |=> !CHIP_NOT_READY_FLAG_OUT)
    else $error("readiness flag still high after sources settled");
  a_ready_flag_high: assert property (
    !CRYSTAL_OSCILLATOR_RUN_IN |-> ##3 CHIP_NOT_READY_FLAG_OUT)
    else $error("readiness flag low while crystal stopped");
  a_state_pass_rx: assert property (
    (MAIN_STATE_IN == `CSB_CODE_RX && !TRANSITIONAL_IN && !ovf_r && !udf_r &&
     !RX_OVERFLOW_IN && !TX_UNDERFLOW_IN) |=> STATE_CODE_OUT == `CSB_CODE_RX)
    else $error("receive state not reported");
  a_transition_idle: assert property (
    (TRANSITIONAL_IN && !ovf_r && !udf_r && !RX_OVERFLOW_IN && !TX_UNDERFLOW_IN)
    |=> STATE_CODE_OUT == `CSB_CODE_IDLE)
    else $error("transitional state not reported as idle");
  a_overrun_code: assert property (
    (RX_OVERFLOW_IN && !TX_UNDERFLOW_IN && !udf_r)
    |=> STATE_CODE_OUT == `CSB_CODE_RX_OVERRUN)
    else $error("receive overrun code missing");
  a_overrun_held: assert property (
    (ovf_r && !RECEIVE_FLUSH_STROBE_IN) |=> ovf_r)
    else $error("receive overrun left without flush");
  a_starved_code: assert property (
    TX_UNDERFLOW_IN |=> STATE_CODE_OUT == `CSB_CODE_TX_STARVED ##1 (udf_r ||
    $past(TRANSMIT_FLUSH_STROBE_IN)))
    else $error("transmit starved code missing or dropped");
  a_idle_power_down: assert property (
    (STATE_CODE_OUT == `CSB_CODE_IDLE) |-> !MODULES_POWER_OUT)
    else $error("modules powered in idle");
  a_rx_count_sat: assert property (
    (offer_upd && RX_FILL_IN >= `CSB_COUNT_SAT) |=> snap.rx_avail == `CSB_COUNT_MAX)
    else $error("receive count not saturated");
  a_tx_free_last: assert property (
    (offer_upd && TX_FILL_IN == `CSB_FIFO_DEPTH - 7'h01) |=> snap.tx_free == 4'h1)
    else $error("one free location not reported");
  a_snapshot_stable: assert property (
    !offer_upd |=> $stable(CHIP_STATUS_SNAPSHOT_OUT[6:0]) && $stable(snap.tx_free))
    else $error("snapshot moved inside a byte slot");

  c_overrun_flush: cover property (ovf_r ##1 RECEIVE_FLUSH_STROBE_IN ##1 !ovf_r);
  c_starved_flush: cover property (udf_r ##1 TRANSMIT_FLUSH_STROBE_IN ##1 !udf_r);
  c_ready_drop: cover property ($fell(CHIP_NOT_READY_FLAG_OUT));
  c_byte_slot: cover property (!cs_s2_r && (tgl_s2_r != tgl_s3_r));

endmodule
`default_nettype wire

// >>> tb/csb_host_model.sv
/*
  Host model: serial bus master that drives the status block's link pins.
  Assumes mode 0 timing and a 125 ns serial clock that runs only inside frames.
*/
`timescale 1ns/100ps
`default_nettype none
module csb_host_model (
  // Serial pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  // Idle levels, clock stands low between frames
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // Select the device and let its output settle
  task automatic select();
    cs_n_out = 1'b0;
    #400;
  endtask

  // Wait for the readiness flag to read low, giving up after 40 polls of 100 ns
  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (so_in !== 1'b0 && n < 40) begin
      #100;
      n++;
    end
    ok = (so_in === 1'b0);
  endtask

  // One byte each way, optional stall before it, top bit first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int gap_ns);
    #(gap_ns);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      #62.5;
      sclk_out = 1'b1;
      rx[i] = so_in;
      #62.5;
      sclk_out = 1'b0;
    end
    si_out = ~tx[0]; // Released data no longer shows the last bit
  endtask

  // End the frame after the last falling edge
  task automatic deselect();
    #62.5;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> tb/spi_chip_status_byte_tb.sv
/*
  Self-checking bench of the chip status byte block with a host model.
  Assumes the block's package, interface and header are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_chip_status_byte_tb;
  logic core_clk, reset_n, xtal, supply, trans, rx_ovf, tx_unf, rx_fl, tx_fl, ok;
  logic sclk, cs_n, si, so, so_oe, nr_flag, power;
  logic [2:0] main_state, code, exp_code;
  logic [6:0] rx_fill, tx_fill;
  logic [7:0] snap;
  logic [31:0] r;
  logic [6:0] rx_c[5] = '{7'h0e, 7'h0f, 7'h40, 7'h00, 7'h01};
  logic [6:0] tx_c[5] = '{7'h31, 7'h32, 7'h40, 7'h00, 7'h3f};
  int failures, n_checks;

  csb_status_top DUT (.CORE_CLK_IN(core_clk), .RESET_N_IN(reset_n), .SPI_SCLK_IN(sclk),
    .SPI_CS_N_IN(cs_n), .SPI_SI_IN(si), .SPI_SO_OUT(so), .SPI_SO_OE_OUT(so_oe),
    .CRYSTAL_OSCILLATOR_RUN_IN(xtal), .SUPPLY_STABLE_IN(supply), .MAIN_STATE_IN(main_state),
    .TRANSITIONAL_IN(trans), .RX_OVERFLOW_IN(rx_ovf), .TX_UNDERFLOW_IN(tx_unf),
    .RECEIVE_FLUSH_STROBE_IN(rx_fl), .TRANSMIT_FLUSH_STROBE_IN(tx_fl), .RX_FILL_IN(rx_fill),
    .TX_FILL_IN(tx_fill), .CHIP_NOT_READY_FLAG_OUT(nr_flag), .STATE_CODE_OUT(code),
    .MODULES_POWER_OUT(power), .CHIP_STATUS_SNAPSHOT_OUT(snap));
  csb_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so));

  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Expected status byte
  function automatic logic [7:0] exp_byte(input logic [2:0] c, input logic rw,
      input logic [6:0] rx, input logic [6:0] tx);
    logic [3:0] cnt;
    if (rw)
      cnt = (rx >= 7'h0f) ? 4'hf : rx[3:0];
    else
      cnt = (tx <= 7'h31) ? 4'hf : 4'(7'h40 - tx);
    return {1'b0, c, cnt};
  endfunction

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict
  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Header plus one data byte, status expected on both
  task automatic frame(input logic rw, input logic [5:0] addr, input logic [7:0] exp);
    logic [7:0] s;
    host.select();
    host.wait_ready(ok);
    chk({7'h00, ok}, 8'h01);
    chk({7'h00, so_oe}, 8'h01);
    host.xfer({rw, 1'b0, addr}, s, 0);
    chk(s, exp);
    host.xfer(8'h5a ^ {8{rw}}, s, 300);
    chk(s, exp);
    host.deselect();
    chk({7'h00, so_oe}, 8'h00);
  endtask

  // Watchdog
  initial begin
    #3000000;
    failures++;
    end_sim();
  end

  // Main sequence
  initial begin
    {reset_n, xtal, supply, trans, rx_ovf, tx_unf, rx_fl, tx_fl} = 8'h00;
    main_state = 3'h0;
    rx_fill = 7'h00;
    tx_fill = 7'h00;
    r = 32'h0000_110f;
    failures = 0;
    n_checks = 0;
    step(6);
    reset_n <= 1'b1;
    // Readiness flag
    host.select();
    chk({6'h00, so, nr_flag}, 8'h03);
    @(posedge core_clk);
    xtal <= 1'b1;
    step(8);
    #1 chk({6'h00, so, nr_flag}, 8'h03);
    @(posedge core_clk);
    supply <= 1'b1;
    host.wait_ready(ok);
    chk({6'h00, ok, nr_flag}, 8'h02);
    host.deselect();
    $display("test readiness done");
    // Random states and fill levels, corners first
    for (int i = 0; i < 24; i++) begin
      r = lfsr(r);
      @(posedge core_clk);
      main_state <= 3'(r[2:0] % 6);
      trans <= (r[7:4] == 4'h0);
      rx_fill <= (i < 5) ? rx_c[i] : 7'(r[15:9] % 65);
      tx_fill <= (i < 5) ? tx_c[i] : 7'(r[22:16] % 65);
      step(10);
      exp_code = trans ? 3'h0 : main_state;
      #1 chk({5'h00, code}, {5'h00, exp_code});
      chk({7'h00, power}, {7'h00, exp_code != 3'h0});
      chk(snap, exp_byte(exp_code, 1'b1, rx_fill, tx_fill));
      // Configuration register access only while idle, FIFO access otherwise
      frame(r[8] ^ i[0], (exp_code == 3'h0) ? 6'h0d : 6'h3f,
        exp_byte(exp_code, r[8] ^ i[0], rx_fill, tx_fill));
    end
    $display("test random done");
    // Sticky faults and flushes
    @(posedge core_clk);
    {main_state, trans, rx_ovf} <= 5'h03;
    @(posedge core_clk);
    rx_ovf <= 1'b0;
    step(3);
    #1 chk({5'h00, code}, 8'h06);
    frame(1'b1, 6'h3f, exp_byte(3'h6, 1'b1, rx_fill, tx_fill));
    @(posedge core_clk);
    {tx_unf, rx_fl} <= 2'h3;
    @(posedge core_clk);
    {tx_unf, rx_fl} <= 2'h0;
    step(3);
    #1 chk({5'h00, code}, 8'h07);
    frame(1'b0, 6'h3f, exp_byte(3'h7, 1'b0, rx_fill, tx_fill));
    @(posedge core_clk);
    {tx_fl, rx_ovf, rx_fl} <= 3'h7;
    @(posedge core_clk);
    {tx_fl, rx_ovf, rx_fl} <= 3'h0;
    step(3);
    #1 chk({5'h00, code}, 8'h06);
    @(posedge core_clk);
    rx_fl <= 1'b1;
    {main_state, trans} <= 4'h2;
    @(posedge core_clk);
    rx_fl <= 1'b0;
    step(3);
    #1 chk({5'h00, code}, 8'h01);
    $display("test faults done");
    end_sim();
  end
endmodule
`default_nettype wire
